// [design/fle10_pkg.sv]
// Purpose : constants and carriers for the tenth fan lookup table entry
// Assumes : AXI4-Lite register access, 32-bit data, one register per word
// Notes   : register indices are byte address divided by four
package fle10_pkg;

  // ------------------------------------------------------------------
  // register indices (byte address = index * 4)
  // ------------------------------------------------------------------
  localparam int          ADDR_W          = 12;
  localparam int          IDX_W           = 10;
  localparam logic [9:0]  IDX_LUT_CTRL    = 10'h04A;
  localparam logic [9:0]  IDX_LUT_OFFSET  = 10'h04E;
  localparam logic [9:0]  IDX_LIMIT       = 10'h062;
  localparam logic [9:0]  IDX_DUTY        = 10'h063;
  localparam logic [9:0]  IDX_LUT_MODE    = 10'h070;
  localparam logic [9:0]  IDX_ENTRY_STAT  = 10'h071;

  // ------------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------------
  localparam int          UNLOCK_BIT      = 5;
  localparam int          MODE_TEMP_HIRES = 0;
  localparam int          MODE_DUTY_HIRES = 1;
  localparam int          MODE_PWM_FAST   = 2;
  localparam int          STAT_ACTIVE     = 0;

  // ------------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------------
  localparam logic [7:0]  RST_LIMIT       = 8'h7F;
  localparam logic [7:0]  RST_DUTY        = 8'h3F;
  localparam logic [7:0]  RST_OFFSET      = 8'h00;
  localparam logic [2:0]  RST_MODE        = 3'h0;

  // ------------------------------------------------------------------
  // bus answers
  // ------------------------------------------------------------------
  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;

  typedef struct packed {
    logic              awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic [2:0]        awprot;
    logic              wvalid;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              bready;
    logic              arvalid;
    logic [ADDR_W-1:0] araddr;
    logic [2:0]        arprot;
    logic              rready;
  } fle10_axi_req_s;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } fle10_axi_rsp_s;

endpackage

// [design/fle10_top.sv]
// What this block does
// RQ1: low-res limit top bit forced zero; high-res uses it as half-degree bit
// RQ2: limit top bit reads back as zero in low-res temperature mode
// RQ3: limit spans 0..127.5 in half steps, or 0..127 whole degrees
// RQ4: temperature above limit drives the PWM output with this entry's duty
// RQ5: compare nine temperature bits in high-res, eight in low-res
// RQ6: limit is always taken as non-negative, sign assumed zero
// RQ7: table offset register adds to the limit for higher set points
// RQ8: low-res duty mode holds the two upper duty bits at zero
// RQ9: high-res duty mode joins upper and lower bits into eight-bit duty
// RQ10: upper duty bits act only at the fastest PWM frequency
// RQ11: low-res duty mode uses the six lower duty bits
// RQ12: both registers always readable; writes only while table unlocked
//
// Purpose : tenth lookup table entry with its AXI4-Lite register slave
// Assumes : I_REMOTE_TEMP is filtered, unsigned, in half-degree steps
// Notes   : decision is registered, one cycle behind temperature/registers
//
// Implementation choice: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
module fle10_top
  import fle10_pkg::*;
(
  input  wire logic           I_CLOCK,
  input  wire logic           I_RST,
  input  wire fle10_axi_req_s I_AXI,
  output fle10_axi_rsp_s      O_AXI,
  input  wire logic [8:0]     I_REMOTE_TEMP,
  input  wire logic [7:0]     I_PWM_DUTY_BELOW,
  output logic                O_ENTRY_ACTIVE,
  output logic [7:0]          O_PWM_DUTY
);

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  typedef struct packed {
    logic              aw_held;
    logic [IDX_W-1:0]  aw_idx;
    logic              w_held;
    logic [7:0]        w_data;
    logic              w_strb0;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              rvalid;
    logic [7:0]        rdata;
    logic [1:0]        rresp;
    logic              unlock;
    logic [7:0]        offset;
    logic [7:0]        limit;
    logic [7:0]        duty;
    logic [2:0]        mode;
    logic              active;
    logic [7:0]        pwm_duty;
  } fle10_state_s;

  fle10_state_s st;
  fle10_state_s next_st;

  logic             temp_hires;
  logic             duty_hires;
  logic             pwm_fast;
  logic [9:0]       temp_cmp;
  logic [9:0]       limit_half;
  logic [7:0]       eff_duty;
  logic             cmp_active;
  logic             wr_do;
  logic             rd_do;
  logic [IDX_W-1:0] rd_idx;
  logic [7:0]       rd_val;
  logic             rd_hit;
  logic             wr_hit;

  assign temp_hires = st.mode[MODE_TEMP_HIRES];
  assign duty_hires = st.mode[MODE_DUTY_HIRES];
  assign pwm_fast   = st.mode[MODE_PWM_FAST];

  // ------------------------------------------------------------------
  // limit comparison
  // ------------------------------------------------------------------
  // low-res drops the half-degree bit of the reading
  assign temp_cmp = temp_hires ? {1'b0, I_REMOTE_TEMP}
                               : {1'b0, I_REMOTE_TEMP[8:1], 1'b0}; // RQ5

  // limit held as unsigned half degrees, so no sign can creep in; offset is whole degrees
  assign limit_half = {2'b00, st.limit[6:0], temp_hires & st.limit[7]} // RQ1 RQ3 RQ6
                    + {1'b0, st.offset, 1'b0};                          // RQ7

  assign cmp_active = temp_cmp > limit_half; // RQ4

  // extended duty bits are dead unless both high-res duty and fast PWM are chosen
  assign eff_duty = (duty_hires && pwm_fast) ? st.duty          // RQ9 RQ10
                                             : {2'b00, st.duty[5:0]}; // RQ8 RQ11

  // ------------------------------------------------------------------
  // register read decode
  // ------------------------------------------------------------------
  assign rd_idx = I_AXI.araddr[ADDR_W-1:2];

  always_comb begin
    rd_hit = 1'b1;
    rd_val = 8'h00;
    case (rd_idx)
      IDX_LUT_CTRL: begin
        rd_val[UNLOCK_BIT] = st.unlock;
      end
      IDX_LUT_OFFSET: begin
        rd_val = st.offset;
      end
      IDX_LIMIT: begin
        rd_val = {temp_hires & st.limit[7], st.limit[6:0]}; // RQ2 RQ12
      end
      IDX_DUTY: begin
        rd_val = duty_hires ? st.duty : {2'b00, st.duty[5:0]}; // RQ8 RQ12
      end
      IDX_LUT_MODE: begin
        rd_val = {5'h00, st.mode};
      end
      IDX_ENTRY_STAT: begin
        rd_val[STAT_ACTIVE] = st.active;
      end
      default: begin
        rd_hit = 1'b0;
      end
    endcase
  end

  always_comb begin
    case (st.aw_idx)
      IDX_LUT_CTRL, IDX_LUT_OFFSET, IDX_LIMIT, IDX_DUTY, IDX_LUT_MODE: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  // ------------------------------------------------------------------
  // next state
  // ------------------------------------------------------------------
  assign wr_do = st.aw_held && st.w_held && !st.bvalid;
  assign rd_do = I_AXI.arvalid && !st.rvalid;

  always_comb begin
    next_st = st;

    // address and data are caught independently, in either order
    if (I_AXI.awvalid && !st.aw_held && !st.bvalid) begin
      next_st.aw_held = 1'b1;
      next_st.aw_idx  = I_AXI.awaddr[ADDR_W-1:2];
    end
    if (I_AXI.wvalid && !st.w_held && !st.bvalid) begin
      next_st.w_held  = 1'b1;
      next_st.w_data  = I_AXI.wdata[7:0];
      next_st.w_strb0 = I_AXI.wstrb[0];
    end

    if (wr_do) begin
      next_st.aw_held = 1'b0;
      next_st.w_held  = 1'b0;
      next_st.bvalid  = 1'b1;
      next_st.bresp   = wr_hit ? RESP_OKAY : RESP_SLVERR;
      // locked limit and duty writes are acknowledged but dropped, as software expects
      if (st.w_strb0) begin
        case (st.aw_idx)
          IDX_LUT_CTRL: begin
            next_st.unlock = st.w_data[UNLOCK_BIT];
          end
          IDX_LUT_OFFSET: begin
            next_st.offset = st.w_data;
          end
          IDX_LIMIT: begin
            if (st.unlock) begin
              next_st.limit = st.w_data; // RQ12
            end
          end
          IDX_DUTY: begin
            if (st.unlock) begin
              next_st.duty = st.w_data; // RQ12
            end
          end
          IDX_LUT_MODE: begin
            next_st.mode = st.w_data[2:0];
          end
          default: begin
          end
        endcase
      end
    end else if (st.bvalid && I_AXI.bready) begin
      next_st.bvalid = 1'b0;
    end

    if (rd_do) begin
      next_st.rvalid = 1'b1;
      next_st.rdata  = rd_val;
      next_st.rresp  = rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (st.rvalid && I_AXI.rready) begin
      next_st.rvalid = 1'b0;
    end

    next_st.active   = cmp_active;
    next_st.pwm_duty = cmp_active ? eff_duty : I_PWM_DUTY_BELOW; // RQ4
  end

  always_ff @(posedge I_CLOCK) begin
    if (I_RST) begin
      st          <= '0;
      st.limit    <= RST_LIMIT;
      st.duty     <= RST_DUTY;
      st.offset   <= RST_OFFSET;
      st.mode     <= RST_MODE;
    end else begin
      st <= next_st;
    end
  end

  // ------------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------------
  assign O_AXI.awready = !st.aw_held && !st.bvalid;
  assign O_AXI.wready  = !st.w_held && !st.bvalid;
  assign O_AXI.bvalid  = st.bvalid;
  assign O_AXI.bresp   = st.bresp;
  assign O_AXI.arready = !st.rvalid;
  assign O_AXI.rvalid  = st.rvalid;
  assign O_AXI.rdata   = {24'h000000, st.rdata};
  assign O_AXI.rresp   = st.rresp;
  assign O_ENTRY_ACTIVE = st.active;
  assign O_PWM_DUTY     = st.pwm_duty;

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  lut_lock_a: assert property ( // RQ12
    @(posedge I_CLOCK) disable iff (I_RST)
    (wr_do && !st.unlock && (st.aw_idx == IDX_LIMIT || st.aw_idx == IDX_DUTY))
      |=> (st.limit == $past(st.limit)) && (st.duty == $past(st.duty)))
    else $error("locked table entry was modified");

  limit_write_a: assert property ( // RQ12
    @(posedge I_CLOCK) disable iff (I_RST)
    (wr_do && st.unlock && st.w_strb0 && st.aw_idx == IDX_LIMIT)
      |=> st.limit == $past(st.w_data) && st.bvalid)
    else $error("unlocked limit write not stored");

  limit_read_a: assert property ( // RQ2
    @(posedge I_CLOCK) disable iff (I_RST)
    (rd_do && rd_idx == IDX_LIMIT && !temp_hires)
      |=> st.rvalid && !st.rdata[7] && st.rdata[6:0] == $past(st.limit[6:0]))
    else $error("low-res limit read shows top bit");

  duty_read_a: assert property ( // RQ8
    @(posedge I_CLOCK) disable iff (I_RST)
    (rd_do && rd_idx == IDX_DUTY && !duty_hires) |=> st.rdata[7:6] == 2'h0)
    else $error("low-res duty read shows upper bits");

  entry_drive_a: assert property ( // RQ4
    @(posedge I_CLOCK) disable iff (I_RST)
    cmp_active |=> O_ENTRY_ACTIVE && O_PWM_DUTY == $past(eff_duty))
    else $error("pwm output not taken from this entry");

  below_pass_a: assert property ( // RQ4
    @(posedge I_CLOCK) disable iff (I_RST)
    !cmp_active |=> !O_ENTRY_ACTIVE && O_PWM_DUTY == $past(I_PWM_DUTY_BELOW))
    else $error("lower entry duty not passed through");

  // judged on the pin, so a slip in the duty mux shows up here
  ext_gate_a: assert property ( // RQ10
    @(posedge I_CLOCK) disable iff (I_RST)
    (cmp_active && !(duty_hires && pwm_fast))
      |=> O_PWM_DUTY == {2'h0, $past(st.duty[5:0])})
    else $error("extended duty bits used outside fast high-res");

  // whole-degree model of the low-res decision, apart from the half-degree datapath
  low_cmp_a: assert property ( // RQ5
    @(posedge I_CLOCK) disable iff (I_RST)
    !temp_hires |-> cmp_active == ({1'b0, I_REMOTE_TEMP[8:1]}
                                   > ({2'b00, st.limit[6:0]} + {1'b0, st.offset})))
    else $error("half-degree bit compared in low-res mode");

  offset_add_a: assert property ( // RQ7
    @(posedge I_CLOCK) disable iff (I_RST)
    limit_half >= {1'b0, st.offset, 1'b0})
    else $error("table offset not added to limit");

  read_hold_a: assert property (
    @(posedge I_CLOCK) disable iff (I_RST)
    (st.rvalid && !I_AXI.rready) |=> st.rvalid && $stable(st.rdata))
    else $error("read answer dropped before taken");

  write_answer_a: assert property (
    @(posedge I_CLOCK) disable iff (I_RST)
    wr_do |=> st.bvalid && !st.aw_held && !st.w_held)
    else $error("write answer missing");

  hires_duty_a: assert property ( // RQ9
    @(posedge I_CLOCK) disable iff (I_RST)
    (cmp_active && duty_hires && pwm_fast) |=> O_PWM_DUTY == $past(st.duty))
    else $error("eight-bit duty not driven in fast high-res");

  duty_write_a: assert property ( // RQ12
    @(posedge I_CLOCK) disable iff (I_RST)
    (wr_do && st.unlock && st.w_strb0 && st.aw_idx == IDX_DUTY)
      |=> st.duty == $past(st.w_data))
    else $error("unlocked duty write not stored");

  read_answer_a: assert property ( // RQ12
    @(posedge I_CLOCK) disable iff (I_RST)
    (rd_do && (rd_idx == IDX_LIMIT || rd_idx == IDX_DUTY))
      |=> st.rvalid && st.rresp == RESP_OKAY)
    else $error("table entry read refused");

endmodule

// [tb/fle10_tb.sv]
// Purpose : self-checking bench for the tenth fan lookup table entry
// Assumes : AXI4-Lite master driven after rising edges, sampled mid-cycle
// Notes   : handshakes are judged at the falling edge, inputs only move at rising edges
`timescale 1ns/100ps
module fle10_tb;
  import fle10_pkg::*;

  logic           clk;
  logic           rst;
  fle10_axi_req_s req;
  fle10_axi_rsp_s rsp;
  logic [8:0]     temp;
  logic [7:0]     below;
  logic           active;
  logic [7:0]     duty;
  int             failures;
  int             num_checks;

  fle10_top uut (
    .I_CLOCK          (clk),
    .I_RST            (rst),
    .I_AXI            (req),
    .O_AXI            (rsp),
    .I_REMOTE_TEMP    (temp),
    .I_PWM_DUTY_BELOW (below),
    .O_ENTRY_ACTIVE   (active),
    .O_PWM_DUTY       (duty)
  );

  initial clk = 1'b0;
  always #20 clk = ~clk;

  // ------------------------------------------------------------------
  // checking and closing
  // ------------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // ------------------------------------------------------------------
  // bus tasks
  // ------------------------------------------------------------------
  task automatic wr(input logic [9:0] idx, input logic [7:0] d, input logic [1:0] exp);
    logic aw_on, w_on, aw_hs, w_hs, b_hs, done;
    logic [1:0] resp;
    int n;
    req.awvalid <= 1'b1;
    req.awaddr  <= {idx, 2'b00};
    req.wvalid  <= 1'b1;
    req.wdata   <= {24'h000000, d};
    req.wstrb   <= 4'hF;
    req.bready  <= 1'b1;
    aw_on = 1'b1;
    w_on  = 1'b1;
    done  = 1'b0;
    n     = 0;
    while (!done && n < 50) begin
      @(negedge clk);
      aw_hs = aw_on && rsp.awready;
      w_hs  = w_on && rsp.wready;
      b_hs  = rsp.bvalid;
      resp  = rsp.bresp;
      @(posedge clk);
      if (aw_hs) begin
        aw_on = 1'b0;
        req.awvalid <= 1'b0;
      end
      if (w_hs) begin
        w_on = 1'b0;
        req.wvalid <= 1'b0;
      end
      if (b_hs) begin
        done = 1'b1;
        req.bready <= 1'b0;
      end
      n++;
    end
    // one idle edge, so the next call never raises bready in the step that lowered it
    @(posedge clk);
    if (!done) failures++;
    check({30'h0, resp}, {30'h0, exp});
  endtask

  task automatic rd(input logic [9:0] idx, input logic [7:0] d, input logic [1:0] exp);
    logic ar_on, done;
    logic [31:0] data;
    logic [1:0] resp;
    int n;
    req.arvalid <= 1'b1;
    req.araddr  <= {idx, 2'b00};
    req.rready  <= 1'b1;
    ar_on = 1'b1;
    done  = 1'b0;
    n     = 0;
    while (!done && n < 50) begin
      @(negedge clk);
      if (rsp.rvalid) begin
        done = 1'b1;
        data = rsp.rdata;
        resp = rsp.rresp;
      end
      if (ar_on && rsp.arready) begin
        ar_on = 1'b0;
        @(posedge clk);
        req.arvalid <= 1'b0;
      end else begin
        @(posedge clk);
      end
      if (done) req.rready <= 1'b0;
      n++;
    end
    @(posedge clk);
    if (!done) failures++;
    check(data, {24'h000000, d});
    check({30'h0, resp}, {30'h0, exp});
  endtask

  // temperature applied, decision is registered so three edges are let pass
  task automatic fn(input logic [8:0] t, input logic a, input logic [7:0] d);
    temp <= t;
    repeat (3) @(posedge clk);
    @(negedge clk);
    check({31'h0, active}, {31'h0, a});
    check({24'h0, duty}, {24'h0, d});
    @(posedge clk);
  endtask

  // ------------------------------------------------------------------
  // tests
  // ------------------------------------------------------------------
  initial begin
    rst = 1'b1;
    req = '0;
    temp = 9'h000;
    below = 8'h5A;
    failures = 0;
    num_checks = 0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    rd(IDX_LIMIT, 8'h7F, RESP_OKAY);
    rd(IDX_DUTY, 8'h3F, RESP_OKAY);
    wr(IDX_LIMIT, 8'h10, RESP_OKAY);
    rd(IDX_LIMIT, 8'h7F, RESP_OKAY);
    wr(IDX_LUT_CTRL, 8'h20, RESP_OKAY);
    rd(IDX_LUT_CTRL, 8'h20, RESP_OKAY);
    wr(IDX_LIMIT, 8'h85, RESP_OKAY);
    rd(IDX_LIMIT, 8'h05, RESP_OKAY);
    wr(IDX_DUTY, 8'hE5, RESP_OKAY);
    rd(IDX_DUTY, 8'h25, RESP_OKAY);
    // low-res limit is 5 degrees; 5.5 degrees truncates to 5 and stays below
    fn(9'h00B, 1'b0, 8'h5A);
    fn(9'h00C, 1'b1, 8'h25);
    rd(IDX_ENTRY_STAT, 8'h01, RESP_OKAY);
    wr(IDX_LUT_MODE, 8'h03, RESP_OKAY);
    rd(IDX_LIMIT, 8'h85, RESP_OKAY);
    rd(IDX_DUTY, 8'hE5, RESP_OKAY);
    fn(9'h00C, 1'b1, 8'h25);
    // high-res limit is 5.5 degrees, equal is not above
    fn(9'h00B, 1'b0, 8'h5A);
    wr(IDX_LUT_MODE, 8'h07, RESP_OKAY);
    rd(IDX_LUT_MODE, 8'h07, RESP_OKAY);
    fn(9'h00C, 1'b1, 8'hE5);
    wr(IDX_LUT_OFFSET, 8'h03, RESP_OKAY);
    rd(IDX_LUT_OFFSET, 8'h03, RESP_OKAY);
    fn(9'h011, 1'b0, 8'h5A);
    fn(9'h012, 1'b1, 8'hE5);
    wr(IDX_LUT_OFFSET, 8'h00, RESP_OKAY);
    // top of range: 127.5 degrees, top bit is no sign
    wr(IDX_LIMIT, 8'hFF, RESP_OKAY);
    fn(9'h0FF, 1'b0, 8'h5A);
    fn(9'h100, 1'b1, 8'hE5);
    wr(IDX_LUT_MODE, 8'h04, RESP_OKAY);
    fn(9'h0FF, 1'b0, 8'h5A);
    below <= 8'hC3;
    fn(9'h0FF, 1'b0, 8'hC3);
    below <= 8'h5A;
    fn(9'h100, 1'b1, 8'h25);
    rd(IDX_ENTRY_STAT, 8'h01, RESP_OKAY);
    wr(IDX_ENTRY_STAT, 8'h00, RESP_SLVERR);
    rd(10'h3FF, 8'h00, RESP_SLVERR);
    wr(IDX_LUT_CTRL, 8'h00, RESP_OKAY);
    wr(IDX_DUTY, 8'h01, RESP_OKAY);
    rd(IDX_DUTY, 8'h25, RESP_OKAY);
    rd(IDX_LUT_CTRL, 8'h00, RESP_OKAY);
    conclude();
  end

  // the whole sequence needs well under 2000 cycles
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    conclude();
  end

endmodule
